// >>> logic/mem_window_pkg.sv
package mem_window_pkg;

    // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [7:0] IDX_DATA_BYTE_TWO   = 8'h06;
    localparam logic [7:0] IDX_DATA_BYTE_THREE = 8'h07;
    localparam logic [7:0] IDX_SOURCE_LOW      = 8'h08;
    localparam logic [7:0] IDX_SOURCE_HIGH     = 8'h09;
    localparam logic [7:0] IDX_ENABLE_LOW      = 8'h0a;
    localparam logic [7:0] IDX_ENABLE_HIGH     = 8'h0b;
    localparam logic [7:0] IDX_ACCESS_CTRL     = 8'h0d;
    localparam logic [7:0] IDX_IRQ_STATUS      = 8'h0e;
    localparam logic [7:0] IDX_IRQ_MASK        = 8'h0f;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned IDX_LSB     = 2;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned MAILBOX_BIT = 0;

    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] LOW_FLAG_MASK = 8'hfe;
    localparam logic [1:0] IRQ_ALL       = 2'h3;
    localparam int unsigned IRQ_EVT_BIT  = 0;
    localparam int unsigned IRQ_HOST_BIT = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // memory access widths of the data window
    typedef enum logic [1:0] {
        ACC_8BIT   = 2'h0,
        ACC_16BIT  = 2'h1,
        ACC_32BIT  = 2'h2,
        ACC_AUTO32 = 2'h3
    } access_type_t;

    // controller side event inputs
    typedef struct packed {
        logic [7:0] set_low;
        logic [7:0] set_high;
        logic [7:0] clear_enable_low;
        logic [7:0] clear_enable_high;
        logic       mailbox_write;
    } ctrl_side_t;

    // a completed register write from the bus slave
    typedef struct packed {
        logic        valid;
        logic [7:0]  idx;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_wr_t;

endpackage

// >>> logic/axil_reg_slave.sv
`timescale 1ns/1ps
module axil_reg_slave (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // axi4-lite write channels
    input  wire logic [7:0]               s_awaddr,
    input  wire logic                     s_awvalid,
    output logic                          s_awready,
    input  wire logic [31:0]              s_wdata,
    input  wire logic [3:0]               s_wstrb,
    input  wire logic                     s_wvalid,
    output logic                          s_wready,
    output logic [1:0]                    s_bresp,
    output logic                          s_bvalid,
    input  wire logic                     s_bready,
    // axi4-lite read channels
    input  wire logic [7:0]               s_araddr,
    input  wire logic                     s_arvalid,
    output logic                          s_arready,
    output logic [31:0]                   s_rdata,
    output logic [1:0]                    s_rresp,
    output logic                          s_rvalid,
    input  wire logic                     s_rready,
    // register side
    output mem_window_pkg::reg_wr_t       wr,
    output logic [7:0]                    rd_idx,
    output logic                          rd_req,
    input  wire logic [31:0]              rd_data,
    input  wire logic                     rd_hit,
    input  wire logic                     wr_hit
);
    import mem_window_pkg::*;

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_idx;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } slave_state_t;

    slave_state_t s_r, s_nxt;
    logic         do_write;
    logic         do_read;

    // a write commits when both halves are held and no response is pending
    assign do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign do_read  = s_arvalid && !s_r.rvalid;

    always_comb begin
        s_nxt = s_r;
        if (s_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_idx = {{IDX_LSB{1'b0}}, s_awaddr[ADDR_W-1:IDX_LSB]};
        end
        if (s_wvalid && !s_r.w_got) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = s_wdata;
            s_nxt.w_strb = s_wstrb;
        end
        if (do_write) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.bvalid && s_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (do_read) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_data;
            s_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.rvalid && s_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bus outputs and write fields straight from state; rd_idx and rd_req from the read address channel
    assign s_awready = !s_r.aw_got;
    assign s_wready  = !s_r.w_got;
    assign s_bvalid  = s_r.bvalid;
    assign s_bresp   = s_r.bresp;
    assign s_arready = !s_r.rvalid;
    assign s_rvalid  = s_r.rvalid;
    assign s_rdata   = s_r.rdata;
    assign s_rresp   = s_r.rresp;
    assign rd_idx    = {{IDX_LSB{1'b0}}, s_araddr[ADDR_W-1:IDX_LSB]};
    assign rd_req    = do_read;
    assign wr.valid  = do_write;
    assign wr.idx    = s_r.aw_idx;
    assign wr.data   = s_r.w_data;
    assign wr.strb   = s_r.w_strb;

    a_bresp_after_both : assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_bvalid) else $error("write response missing");
    a_rvalid_hold : assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read data dropped");
endmodule // axil_reg_slave

// >>> logic/event_flag_byte.sv
`timescale 1ns/1ps
module event_flag_byte (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // controller side
    input  wire logic [7:0]  set_in,
    input  wire logic [7:0]  clear_enable,
    // host side
    input  wire logic        host_wr,
    input  wire logic [7:0]  host_data,
    input  wire logic [7:0]  implemented,
    // flag state
    output logic [7:0]       flags
);
    import mem_window_pkg::*;

    typedef struct packed {
        logic [7:0] flags;
    } flag_state_t;

    flag_state_t f_r, f_nxt;
    logic [7:0]  clr;

    // write-one clear gated by the controller's clear enables, set beats clear
    always_comb begin
        clr         = host_wr ? (host_data & clear_enable) : BYTE_ZERO;
        f_nxt       = f_r;
        f_nxt.flags = ((f_r.flags & ~clr) | set_in) & implemented;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

    assign flags = f_r.flags;

    a_clear_blocked : assert property (@(posedge aclk) disable iff (!aresetn)
        host_wr && (host_data[0] & ~clear_enable[0]) && flags[0] |=> flags[0])
        else $error("disabled clear took effect");
    a_set_wins : assert property (@(posedge aclk) disable iff (!aresetn)
        (set_in[1] & implemented[1]) |=> flags[1])
        else $error("set lost");
endmodule // event_flag_byte

// >>> logic/host_mem_window_irq_regs.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module host_mem_window_irq_regs (
    // clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // axi4-lite slave
    input  wire logic [7:0]                 s_awaddr,
    input  wire logic                       s_awvalid,
    output logic                            s_awready,
    input  wire logic [31:0]                s_wdata,
    input  wire logic [3:0]                 s_wstrb,
    input  wire logic                       s_wvalid,
    output logic                            s_wready,
    output logic [1:0]                      s_bresp,
    output logic                            s_bvalid,
    input  wire logic                       s_bready,
    input  wire logic [7:0]                 s_araddr,
    input  wire logic                       s_arvalid,
    output logic                            s_arready,
    output logic [31:0]                     s_rdata,
    output logic [1:0]                      s_rresp,
    output logic                            s_rvalid,
    input  wire logic                       s_rready,
    // controller side
    input  mem_window_pkg::ctrl_side_t      ctrl,
    // memory window toward controller memory
    output logic [15:0]                     window_data_upper,
    output logic                            window_wr_pulse,
    output logic                            window_rd_pulse,
    output mem_window_pkg::access_type_t    window_access,
    // interrupts
    output logic                            host_firmware_event,
    output logic                            irq
);
    import mem_window_pkg::*;

    typedef struct packed {
        logic [7:0]   window_data_bits_23_16;
        logic [7:0]   window_data_bits_31_24;
        logic [7:0]   enable_low;
        logic [7:0]   firmware_event_enables_high;
        access_type_t access;
        logic         wr_pulse;
        logic         rd_pulse;
        logic         host_event;
        logic [1:0]   irq_status;
        logic [1:0]   irq_mask;
        logic         irq;
    } regs_state_t;

    regs_state_t  r_r, r_nxt;
    reg_wr_t      wr;
    logic [7:0]   rd_idx;
    logic         rd_req;
    logic [31:0]  rd_data;
    logic         rd_hit;
    logic         wr_hit;
    logic [7:0]   firmware_event_flags_low;
    logic [7:0]   firmware_event_flags_high;
    logic [7:0]   low_set;
    logic         wr_src_low;
    logic         wr_src_high;
    logic         event_now;
    logic         host_ev_prev_r;

    // index decode shared by read and write
    function automatic logic idx_known(input logic [7:0] idx);
        return idx inside {IDX_DATA_BYTE_TWO, IDX_DATA_BYTE_THREE, IDX_SOURCE_LOW, IDX_SOURCE_HIGH,
                           IDX_ENABLE_LOW, IDX_ENABLE_HIGH, IDX_ACCESS_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    endfunction

    // byte-lane merge for an 8-bit register
    function automatic logic [7:0] lane0(input logic [7:0] old, input reg_wr_t w);
        return w.strb[0] ? w.data[BYTE_W-1:0] : old;
    endfunction

    axil_reg_slave u_slave (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr        (wr),
        .rd_idx    (rd_idx),
        .rd_req    (rd_req),
        .rd_data   (rd_data),
        .rd_hit    (rd_hit),
        .wr_hit    (wr_hit)
    );

    // source byte write strobes
    assign wr_src_low  = wr.valid && wr.idx == IDX_SOURCE_LOW && wr.strb[0];
    assign wr_src_high = wr.valid && wr.idx == IDX_SOURCE_HIGH && wr.strb[0];
    // bit 0 is set by the mailbox write only; host clear mask excludes it
    assign low_set     = (ctrl.set_low & LOW_FLAG_MASK) | {7'h00, ctrl.mailbox_write};

    event_flag_byte u_flags_low (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .set_in       (low_set),
        .clear_enable (ctrl.clear_enable_low & LOW_FLAG_MASK),
        .host_wr      (wr_src_low),
        .host_data    (wr.data[BYTE_W-1:0]),
        .implemented  (8'hff),
        .flags        (firmware_event_flags_low)
    );

    event_flag_byte u_flags_high (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .set_in       (ctrl.set_high),
        .clear_enable (ctrl.clear_enable_high),
        .host_wr      (wr_src_high),
        .host_data    (wr.data[BYTE_W-1:0]),
        .implemented  (8'hff),
        .flags        (firmware_event_flags_high)
    );

    // combined host event from enabled flags
    assign event_now = |(firmware_event_flags_low & r_r.enable_low)
                     | |(firmware_event_flags_high & r_r.firmware_event_enables_high);

    assign wr_hit = idx_known(wr.idx);
    assign rd_hit = idx_known(rd_idx);

    // read mux
    always_comb begin
        rd_data = '0;
        unique case (rd_idx)
            IDX_DATA_BYTE_TWO:   rd_data[BYTE_W-1:0] = r_r.window_data_bits_23_16;
            IDX_DATA_BYTE_THREE: rd_data[BYTE_W-1:0] = r_r.window_data_bits_31_24;
            IDX_SOURCE_LOW:      rd_data[BYTE_W-1:0] = firmware_event_flags_low;
            IDX_SOURCE_HIGH:     rd_data[BYTE_W-1:0] = firmware_event_flags_high;
            IDX_ENABLE_LOW:      rd_data[BYTE_W-1:0] = r_r.enable_low;
            IDX_ENABLE_HIGH:     rd_data[BYTE_W-1:0] = r_r.firmware_event_enables_high;
            IDX_ACCESS_CTRL:     rd_data[1:0] = r_r.access;
            IDX_IRQ_STATUS:      rd_data[1:0] = r_r.irq_status;
            IDX_IRQ_MASK:        rd_data[1:0] = r_r.irq_mask;
            default:             rd_data = '0;
        endcase
    end

    // register writes, window strobes and interrupt state
    always_comb begin
        r_nxt            = r_r;
        r_nxt.wr_pulse   = 1'b0;
        r_nxt.rd_pulse   = 1'b0;
        r_nxt.host_event = event_now;
        if (wr.valid) begin
            unique case (wr.idx)
                IDX_DATA_BYTE_TWO: begin
                    r_nxt.window_data_bits_23_16 = lane0(r_r.window_data_bits_23_16, wr);
                    r_nxt.wr_pulse = wr.strb[0];
                end
                IDX_DATA_BYTE_THREE: begin
                    r_nxt.window_data_bits_31_24 = lane0(r_r.window_data_bits_31_24, wr);
                    r_nxt.wr_pulse = wr.strb[0];
                end
                IDX_ENABLE_LOW:  r_nxt.enable_low = lane0(r_r.enable_low, wr);
                IDX_ENABLE_HIGH: r_nxt.firmware_event_enables_high =
                                     lane0(r_r.firmware_event_enables_high, wr);
                IDX_ACCESS_CTRL: begin
                    if (wr.strb[0]) begin
                        r_nxt.access = access_type_t'(wr.data[1:0]);
                    end
                end
                IDX_IRQ_STATUS: begin
                    if (wr.strb[0]) begin
                        r_nxt.irq_status = r_r.irq_status & ~wr.data[1:0];
                    end
                end
                IDX_IRQ_MASK: begin
                    if (wr.strb[0]) begin
                        r_nxt.irq_mask = wr.data[1:0];
                    end
                end
                default: ;
            endcase
        end
        // host reads of the window bytes fetch from controller memory
        if (rd_req && (rd_idx == IDX_DATA_BYTE_TWO || rd_idx == IDX_DATA_BYTE_THREE)) begin
            r_nxt.rd_pulse = 1'b1;
        end
        // sticky status: set wins over clear
        r_nxt.irq_status[IRQ_EVT_BIT]  = r_nxt.irq_status[IRQ_EVT_BIT] | (event_now & ~host_ev_prev_r);
        r_nxt.irq_status[IRQ_HOST_BIT] = r_nxt.irq_status[IRQ_HOST_BIT] | wr.valid;
        r_nxt.irq = |(r_nxt.irq_status & r_nxt.irq_mask & IRQ_ALL);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r            <= '0;
            host_ev_prev_r <= 1'b0;
        end else begin
            r_r            <= r_nxt;
            host_ev_prev_r <= event_now;
        end
    end

    // outputs from flip-flops
    assign window_data_upper   = {r_r.window_data_bits_31_24, r_r.window_data_bits_23_16};
    assign window_wr_pulse     = r_r.wr_pulse;
    assign window_rd_pulse     = r_r.rd_pulse;
    assign window_access       = r_r.access;
    assign host_firmware_event = r_r.host_event;
    assign irq                 = r_r.irq;

    sequence s_mailbox_written;
        ctrl.mailbox_write;
    endsequence

    a_mailbox_sets : assert property (@(posedge aclk) disable iff (!aresetn)
        s_mailbox_written |=> firmware_event_flags_low[MAILBOX_BIT]) else $error("mailbox flag not set");
    a_mailbox_gate : assert property (@(posedge aclk) disable iff (!aresetn)
        firmware_event_flags_low[MAILBOX_BIT] && r_r.enable_low[MAILBOX_BIT]
        |=> host_firmware_event) else $error("enabled mailbox flag not forwarded");
    a_low_gate : assert property (@(posedge aclk) disable iff (!aresetn)
        |(firmware_event_flags_low & r_r.enable_low & LOW_FLAG_MASK) |=> host_firmware_event)
        else $error("enabled low flag not forwarded");
    a_high_gate : assert property (@(posedge aclk) disable iff (!aresetn)
        |(firmware_event_flags_high & r_r.firmware_event_enables_high) |=> host_firmware_event)
        else $error("enabled high flag not forwarded");
    a_event_quiet : assert property (@(posedge aclk) disable iff (!aresetn)
        !event_now |=> !host_firmware_event) else $error("event without enabled flag");
    a_w1c_clear : assert property (@(posedge aclk) disable iff (!aresetn)
        wr_src_high && wr.data[0] && ctrl.clear_enable_high[0] && !ctrl.set_high[0]
        |=> !firmware_event_flags_high[0]) else $error("write one did not clear");
    a_w1c_blocked : assert property (@(posedge aclk) disable iff (!aresetn)
        wr_src_low && firmware_event_flags_low[1] && !ctrl.clear_enable_low[1]
        |=> firmware_event_flags_low[1]) else $error("blocked clear took effect");
    a_byte_two_store : assert property (@(posedge aclk) disable iff (!aresetn)
        wr.valid && wr.idx == IDX_DATA_BYTE_TWO && wr.strb[0]
        |=> window_data_upper[BYTE_W-1:0] == $past(wr.data[BYTE_W-1:0])) else $error("byte two lost");
    a_byte_three_store : assert property (@(posedge aclk) disable iff (!aresetn)
        wr.valid && wr.idx == IDX_DATA_BYTE_THREE && wr.strb[0]
        |=> window_data_upper[15:BYTE_W] == $past(wr.data[BYTE_W-1:0])) else $error("byte three lost");
    a_access_store : assert property (@(posedge aclk) disable iff (!aresetn)
        wr.valid && wr.idx == IDX_ACCESS_CTRL && wr.strb[0]
        |=> window_access == $past(wr.data[1:0])) else $error("access type lost");
    a_reset_clear : assert property (@(posedge aclk)
        !aresetn |=> firmware_event_flags_low == BYTE_ZERO && window_data_upper == '0)
        else $error("reset did not clear");
endmodule // host_mem_window_irq_regs

// >>> verif/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model (
    // clock
    input  wire logic                  aclk,
    // controller side toward the block
    output mem_window_pkg::ctrl_side_t ctrl
);
    import mem_window_pkg::*;

    // idle: no set requests, host clears gated off
    initial ctrl = '0;

    // one-cycle firmware set request and mailbox write pulse
    task automatic raise(input logic [7:0] lo, input logic [7:0] hi, input logic mbox);
        @(posedge aclk);
        ctrl.set_low       <= lo;
        ctrl.set_high      <= hi;
        ctrl.mailbox_write <= mbox;
        @(posedge aclk);
        ctrl.set_low       <= 8'h00;
        ctrl.set_high      <= 8'h00;
        ctrl.mailbox_write <= 1'b0;
    endtask

    // host clear enables, held as levels
    task automatic gate(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge aclk);
        ctrl.clear_enable_low  <= lo;
        ctrl.clear_enable_high <= hi;
    endtask
endmodule // ctrl_model

// >>> verif/host_mem_window_irq_regs_tb.sv
`timescale 1ns/1ps
module host_mem_window_irq_regs_tb;
    import mem_window_pkg::*;

    // clock, reset, bus master signals
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    ctrl_side_t  ctrl;
    logic [15:0] win_up;
    logic        win_wr, win_rd, evt, irq;
    access_type_t win_acc;
    int          err_total = 0, total_checks = 0, cyc = 0;
    int          wr_seen = 0, rd_seen = 0;

    always #4 aclk = ~aclk;

    ctrl_model ctrl_u (.aclk(aclk), .ctrl(ctrl));

    host_mem_window_irq_regs dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'h1),
        .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready), .ctrl(ctrl), .window_data_upper(win_up),
        .window_wr_pulse(win_wr), .window_rd_pulse(win_rd), .window_access(win_acc),
        .host_firmware_event(evt), .irq(irq));

    // verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // count window strobe pulses
    always @(posedge aclk) begin
        if (win_wr) wr_seen <= wr_seen + 1;
        if (win_rd) rd_seen <= rd_seen + 1;
    end

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write: address and data offered together, each released when taken
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rexp);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin a = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w = 1'b1; wvalid <= 1'b0; end
        end while (!(a && w && bvalid));
        chk("bresp", {30'h0, rexp}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    // read and compare data and response
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] rexp);
        logic a;
        a = 1'b0;
        @(posedge aclk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin a = 1'b1; arvalid <= 1'b0; end
        end while (!(a && rvalid));
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, rexp}, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    // let event, status and irq stages land
    task automatic settle();
        repeat (4) @(posedge aclk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 6; i <= 11; i++) rchk(8'(i), 32'h0, RESP_OKAY);
    endtask

    task automatic t_window();
        int w0, r0;
        w0 = wr_seen;
        r0 = rd_seen;
        wreg(IDX_DATA_BYTE_TWO, 8'ha5, RESP_OKAY);
        wreg(IDX_DATA_BYTE_THREE, 8'h3c, RESP_OKAY);
        rchk(IDX_DATA_BYTE_TWO, 32'ha5, RESP_OKAY);
        rchk(IDX_DATA_BYTE_THREE, 32'h3c, RESP_OKAY);
        chk("window_data_upper", 32'h3ca5, {16'h0, win_up});
        for (int i = 0; i < 4; i++) begin
            wreg(IDX_ACCESS_CTRL, 8'(i), RESP_OKAY);
            settle();
            chk("window_access", 32'(i), {30'h0, win_acc});
        end
        chk("window_wr_pulse", 32'(w0 + 2), 32'(wr_seen));
        chk("window_rd_pulse", 32'(r0 + 2), 32'(rd_seen));
        rchk(8'h10, 32'h0, RESP_SLVERR);
        wreg(8'h10, 8'hff, RESP_SLVERR);
    endtask

    task automatic t_flags();
        ctrl_u.raise(8'hfe, 8'hff, 1'b0);
        rchk(IDX_SOURCE_LOW, 32'hfe, RESP_OKAY);
        rchk(IDX_SOURCE_HIGH, 32'hff, RESP_OKAY);
        ctrl_u.gate(8'h0e, 8'hf0);
        wreg(IDX_SOURCE_LOW, 8'hff, RESP_OKAY);
        rchk(IDX_SOURCE_LOW, 32'hf0, RESP_OKAY);
        wreg(IDX_SOURCE_HIGH, 8'h0f, RESP_OKAY);
        wreg(IDX_SOURCE_HIGH, 8'h00, RESP_OKAY);
        rchk(IDX_SOURCE_HIGH, 32'hff, RESP_OKAY);
        wreg(IDX_SOURCE_HIGH, 8'hf0, RESP_OKAY);
        rchk(IDX_SOURCE_HIGH, 32'h0f, RESP_OKAY);
        ctrl_u.raise(8'h00, 8'h00, 1'b1);
        rchk(IDX_SOURCE_LOW, 32'hf1, RESP_OKAY);
        ctrl_u.gate(8'hff, 8'hff);
        wreg(IDX_SOURCE_LOW, 8'hff, RESP_OKAY);
        rchk(IDX_SOURCE_LOW, 32'h01, RESP_OKAY);
    endtask

    // enable byte, value, expected host event
    task automatic en_step(input logic [7:0] idx, input logic [7:0] d, input logic exp);
        wreg(idx, d, RESP_OKAY);
        settle();
        chk("host_firmware_event", {31'h0, exp}, {31'h0, evt});
    endtask

    task automatic t_enables();
        en_step(IDX_ENABLE_LOW, 8'h01, 1'b1);
        en_step(IDX_ENABLE_LOW, 8'h00, 1'b0);
        en_step(IDX_ENABLE_HIGH, 8'h08, 1'b1);
        en_step(IDX_ENABLE_HIGH, 8'h00, 1'b0);
        ctrl_u.raise(8'h02, 8'h00, 1'b0);
        en_step(IDX_ENABLE_LOW, 8'h02, 1'b1);
        en_step(IDX_ENABLE_LOW, 8'hfc, 1'b0);
    endtask

    // status sticky bit, mask and write-one clear
    task automatic t_irq();
        wreg(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
        wreg(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
        en_step(IDX_IRQ_MASK, 8'h01, 1'b0);
        chk("irq", 32'h0, {31'h0, irq});
        en_step(IDX_ENABLE_LOW, 8'h02, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        en_step(IDX_IRQ_MASK, 8'h00, 1'b1);
        chk("irq", 32'h0, {31'h0, irq});
        en_step(IDX_IRQ_MASK, 8'h01, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        en_step(IDX_IRQ_STATUS, 8'h01, 1'b1);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    // main sequence
    initial begin
        do_reset();
        t_window();
        t_flags();
        t_enables();
        t_irq();
        do_reset();
        end_of_test();
    end
endmodule // host_mem_window_irq_regs_tb
